// *** csf_charger_irq.sv ***
// Charger source qualification, fault response, indicator and interrupt pulse logic
// Overview of operation
// - Good source: status high, pin low, flag, pulse
// - Qualify: in range, above hysteresis 30ms load
// - Indicator disable bit stops indicator pin drive
// - Indicator low while charging, not top-off
// - Indicator released when done, suspended, idle
// - Fault suspends charging: indicator blinks 1Hz
// - Each reportable update: one 256us low pulse
// - Default events all produce interrupt pulses
// - Rising edge of any status bit pulses
// - Mask set: no pulse, status/flag still update
// - Live status bit plus latched flag bit
// - Read clears flags; only fresh edge resets
// - Single input: line overvoltage opens switch pair
// - Dual input: overvoltage swaps to other input
// - Bus overvoltage: stop, regulator on, blink
// - Weak source: stop, clear, requalify, redetect
// - Rail overvoltage: stop, sink on, report
// - Short under current limit: retry, 7 fails suspend
// - Retry off: keep switching, cycle limit
// - Short entry sets status, flag, pulse
// - Cell overvoltage while charging stops charging
// - Cell sink only with discharge enable bit
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module csf_charger_irq #(
	parameter longint LOAD_CYC = csf_pkg::LOAD_CYC,
	parameter longint IRQ_CYC = csf_pkg::IRQ_CYC,
	parameter longint BLINK_CYC = csf_pkg::BLINK_CYC,
	parameter longint RETRY_CYC = csf_pkg::RETRY_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Comparator levels
	input wire logic busPresent,
	input wire logic busOvervoltage,
	input wire logic busAboveWeakHys,
	input wire logic weakSource,
	input wire logic [1:0] lineOvervoltage,
	input wire logic dualInput,
	input wire logic railOvervoltage,
	input wire logic railShort,
	input wire logic inputCurrentLimitLoop,
	input wire logic cellOvervoltage,
	input wire logic portDetectDone,
	input wire logic [csf_pkg::NEXT-1:0] extEvents,
	input wire logic [3:0] sourceTypeField,
	input wire logic [2:0] thermistorZoneStatus,
	input wire logic [2:0] chargePhaseField,
	// Charger state
	input wire logic charging,
	input wire logic topOff,
	// Pins and control outputs
	output logic power_good_n,
	output logic chgIndOut,
	output logic chgIndOe,
	output logic irq_pulse_n,
	output logic switchEn,
	output logic chargeEn,
	output logic internalRegulatorEn,
	output logic [1:0] inputSwitchDriveEn,
	output logic loadTestSinkEn,
	output logic detectReq,
	output logic railSinkEn,
	output logic cellSinkEn,
	output logic cycleLimitEn
);
	csf_pkg::csf_qual_t qState_q;
	csf_pkg::csf_short_t sState_q;
	logic [31:0] qCnt_q, irqCnt_q, blinkCnt_q, sCnt_q;
	logic [3:0] ctrl_q;
	logic [csf_pkg::NEV-1:0] stat_q, flag_q, mask_q, statNow, rise, rdClr;
	logic [9:0] fld_q;
	logic [2:0] fails_q;
	logic sel_q, blink_q, pend_q, fire, qualOk, shortCond, fault;
	logic awHave_q, wHave_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic doWrite, doRead;
	logic [1:0] lineOpen;

	// Source qualification: in window and holding up under the load sink
	assign qualOk = busPresent && !busOvervoltage && busAboveWeakHys;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			qState_q <= csf_pkg::Q_IDLE;
			qCnt_q <= 32'h0;
		end else begin
			case (qState_q)
				csf_pkg::Q_IDLE: begin
					qCnt_q <= 32'h0;
					if (qualOk) qState_q <= csf_pkg::Q_TEST;
				end
				csf_pkg::Q_TEST: begin
					qCnt_q <= qCnt_q + 32'h1;
					if (!qualOk) qState_q <= csf_pkg::Q_IDLE;
					else if (qCnt_q == 32'(LOAD_CYC - 1)) qState_q <= csf_pkg::Q_GOOD;
				end
				csf_pkg::Q_GOOD: begin
					if (weakSource || !busPresent) qState_q <= csf_pkg::Q_IDLE;
				end
				default: qState_q <= csf_pkg::Q_IDLE;
			endcase
		end
	end

	// Line overvoltage: single input opens its pair, dual swaps inputs
	always_comb begin
		lineOpen = lineOvervoltage;
		if (dualInput) lineOpen = {sel_q == 1'b0, sel_q == 1'b1};
		else lineOpen = {1'b1, lineOvervoltage[0]};
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) sel_q <= 1'b0;
		else if (dualInput && lineOvervoltage[sel_q] && !lineOvervoltage[!sel_q])
			sel_q <= !sel_q;
	end

	// Live status vector; field change is a one-cycle event bit
	always_comb begin
		statNow = '0;
		statNow[csf_pkg::EV_SRC] = qState_q == csf_pkg::Q_GOOD;
		statNow[csf_pkg::EV_BUSOV] = busOvervoltage;
		statNow[csf_pkg::EV_LINE0] = lineOvervoltage[0];
		statNow[csf_pkg::EV_LINE1] = lineOvervoltage[1];
		statNow[csf_pkg::EV_RAILOV] = railOvervoltage;
		statNow[csf_pkg::EV_SHORT] = shortCond;
		statNow[csf_pkg::EV_CELLOV] = cellOvervoltage && charging;
		statNow[csf_pkg::EV_EXT +: csf_pkg::NEXT] = extEvents;
		statNow[csf_pkg::EV_PORT] = statNow[csf_pkg::EV_SRC] && portDetectDone;
		statNow[csf_pkg::EV_FLD] = fld_q != {sourceTypeField, thermistorZoneStatus, chargePhaseField};
	end
	assign rise = statNow & ~stat_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stat_q <= '0;
			fld_q <= 10'h000;
		end else begin
			stat_q <= statNow;
			fld_q <= {sourceTypeField, thermistorZoneStatus, chargePhaseField};
		end
	end

	// Sticky flags: a fresh edge in the read cycle survives the clear
	genvar gi;
	generate
		for (gi = 0; gi < csf_pkg::NEV; gi++) begin : gFlag
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) flag_q[gi] <= 1'b0;
				else if (rise[gi]) flag_q[gi] <= 1'b1;
				else if (rdClr[gi]) flag_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// Interrupt pulse; events during a pulse queue one more pulse
	assign fire = |(rise & ~mask_q);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
			irqCnt_q <= 32'h0;
			irq_pulse_n <= 1'b1;
		end else begin
			if (irq_pulse_n && (pend_q || fire)) begin
				irq_pulse_n <= 1'b0;
				irqCnt_q <= 32'h0;
				pend_q <= 1'b0;
			end else begin
				if (fire) pend_q <= 1'b1;
				if (!irq_pulse_n) begin
					irqCnt_q <= irqCnt_q + 32'h1;
					if (irqCnt_q == 32'(IRQ_CYC - 1)) irq_pulse_n <= 1'b1;
				end
			end
		end
	end

	// Rail short retry with consecutive failure count
	assign shortCond = railShort && inputCurrentLimitLoop;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sState_q <= csf_pkg::S_IDLE;
			sCnt_q <= 32'h0;
			fails_q <= 3'h0;
		end else begin
			case (sState_q)
				csf_pkg::S_IDLE: begin
					sCnt_q <= 32'h0;
					if (shortCond && !ctrl_q[csf_pkg::CTL_RETRY_OFF]) begin
						sState_q <= csf_pkg::S_HOLD;
						fails_q <= 3'h0;
					end
				end
				csf_pkg::S_HOLD: begin
					sCnt_q <= sCnt_q + 32'h1;
					if (sCnt_q == 32'(RETRY_CYC - 1)) begin
						sState_q <= csf_pkg::S_WATCH;
						sCnt_q <= 32'h0;
					end
				end
				csf_pkg::S_WATCH: begin
					sCnt_q <= sCnt_q + 32'h1;
					if (shortCond) begin
						fails_q <= fails_q + 3'h1;
						sCnt_q <= 32'h0;
						if (fails_q + 3'h1 == csf_pkg::SHORT_TRIES) sState_q <= csf_pkg::S_IDLE;
						else sState_q <= csf_pkg::S_HOLD;
					end else if (sCnt_q == 32'(RETRY_CYC - 1)) begin
						sState_q <= csf_pkg::S_IDLE;
						fails_q <= 3'h0;
					end
				end
				default: sState_q <= csf_pkg::S_IDLE;
			endcase
		end
	end

	// Blink timebase, about half a second high then half low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			blinkCnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else if (blinkCnt_q == 32'(BLINK_CYC - 1)) begin
			blinkCnt_q <= 32'h0;
			blink_q <= !blink_q;
		end else begin
			blinkCnt_q <= blinkCnt_q + 32'h1;
		end
	end

	// Fault responses and pin drive, all registered
	assign fault = busOvervoltage || railOvervoltage || statNow[csf_pkg::EV_CELLOV]
		|| (sState_q != csf_pkg::S_IDLE) || (|lineOvervoltage);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			power_good_n <= 1'b1;
			chgIndOut <= 1'b0;
			chgIndOe <= 1'b0;
			switchEn <= 1'b0;
			chargeEn <= 1'b0;
			internalRegulatorEn <= 1'b0;
			inputSwitchDriveEn <= 2'h0;
			loadTestSinkEn <= 1'b0;
			detectReq <= 1'b0;
			railSinkEn <= 1'b0;
			cellSinkEn <= 1'b0;
			cycleLimitEn <= 1'b0;
		end else begin
			power_good_n <= !(statNow[csf_pkg::EV_SRC] && !busOvervoltage);
			chgIndOut <= 1'b0;
			if (ctrl_q[csf_pkg::CTL_IND_DIS]) chgIndOe <= 1'b0;
			else if (fault) chgIndOe <= blink_q;
			else chgIndOe <= charging && !topOff && !ctrl_q[csf_pkg::CTL_SUSPEND];
			// Overvoltage on the active line gates switching off here directly, not through the bus
			switchEn <= statNow[csf_pkg::EV_PORT] && !busOvervoltage && !railOvervoltage
				&& !(|(lineOvervoltage & ~lineOpen)) && !(dualInput ? 1'b0 : lineOvervoltage[0])
				&& sState_q != csf_pkg::S_HOLD && !ctrl_q[csf_pkg::CTL_SUSPEND];
			chargeEn <= !statNow[csf_pkg::EV_CELLOV];
			internalRegulatorEn <= busPresent;
			inputSwitchDriveEn <= ~lineOpen;
			loadTestSinkEn <= qState_q == csf_pkg::Q_TEST;
			detectReq <= statNow[csf_pkg::EV_SRC] && !portDetectDone;
			railSinkEn <= railOvervoltage;
			cellSinkEn <= statNow[csf_pkg::EV_CELLOV] && ctrl_q[csf_pkg::CTL_CELL_DIS];
			cycleLimitEn <= shortCond && ctrl_q[csf_pkg::CTL_RETRY_OFF];
		end
	end

	// Write channel: address and data accepted in either order
	assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0;
			wStrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= csf_pkg::RESP_OK;
		end else begin
			s_axi_awready <= !awHave_q && !s_axi_awready;
			s_axi_wready <= !wHave_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_q == csf_pkg::OFS_CTRL || awAddr_q == csf_pkg::OFS_MASK)
					? csf_pkg::RESP_OK : csf_pkg::RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Writable registers; the short retry sets suspend over a software write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q <= csf_pkg::CTL_RESET;
			mask_q <= csf_pkg::MASK_RESET;
		end else begin
			if (doWrite && awAddr_q == csf_pkg::OFS_CTRL && wStrb_q[0]) ctrl_q <= wData_q[3:0];
			if (doWrite && awAddr_q == csf_pkg::OFS_MASK) begin
				if (wStrb_q[0]) mask_q[7:0] <= wData_q[7:0];
				if (wStrb_q[1]) mask_q[15:8] <= wData_q[15:8];
				if (wStrb_q[2]) mask_q[16] <= wData_q[16];
			end
			if (sState_q == csf_pkg::S_WATCH && shortCond && fails_q + 3'h1 == csf_pkg::SHORT_TRIES)
				ctrl_q[csf_pkg::CTL_SUSPEND] <= 1'b1;
		end
	end

	// Read channel; reading the flag register clears what it returned
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign rdClr = (doRead && s_axi_araddr == csf_pkg::OFS_FLAG) ? flag_q : '0;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= csf_pkg::RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (doRead) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= csf_pkg::RESP_OK;
				case (s_axi_araddr)
					csf_pkg::OFS_CTRL: s_axi_rdata <= {28'h0, ctrl_q};
					csf_pkg::OFS_STAT: s_axi_rdata <= {15'h0, stat_q};
					csf_pkg::OFS_FLAG: s_axi_rdata <= {15'h0, flag_q};
					csf_pkg::OFS_MASK: s_axi_rdata <= {15'h0, mask_q};
					csf_pkg::OFS_FLD: s_axi_rdata <= {22'h0, fld_q};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= csf_pkg::RESP_ERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	sequence sPulseStart;
		irq_pulse_n && (pend_q || fire);
	endsequence
	a_pg_on_good: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(stat_q[csf_pkg::EV_SRC]) && !busOvervoltage |-> !power_good_n)
		else $error("power good pin not low after source qualified");
	a_test_abort: assert property (@(posedge clk_sys) disable iff (rst)
		qState_q == csf_pkg::Q_TEST && !qualOk |=> qState_q == csf_pkg::Q_IDLE)
		else $error("load test not aborted on bad bus");
	a_ind_off: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q[csf_pkg::CTL_IND_DIS] |=> !chgIndOe)
		else $error("indicator driven while disabled");
	a_blink_fault: assert property (@(posedge clk_sys) disable iff (rst)
		fault && !ctrl_q[csf_pkg::CTL_IND_DIS] |=> chgIndOe == $past(blink_q))
		else $error("indicator not blinking in fault");
	a_pulse_start: assert property (@(posedge clk_sys) disable iff (rst)
		sPulseStart |=> !irq_pulse_n ##1 !irq_pulse_n)
		else $error("interrupt pulse did not start");
	a_pulse_width: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(irq_pulse_n) |-> $past(irqCnt_q) == 32'(IRQ_CYC - 1))
		else $error("interrupt pulse width wrong");
	a_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
		rise[csf_pkg::EV_BUSOV] |=> flag_q[csf_pkg::EV_BUSOV])
		else $error("flag not set on status edge");
	a_mask_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		irq_pulse_n && !pend_q && !(|(statNow & ~stat_q & ~mask_q)) |=> irq_pulse_n)
		else $error("interrupt pulse without unmasked event");
	a_line_open: assert property (@(posedge clk_sys) disable iff (rst)
		!dualInput && lineOvervoltage[0] |=> !inputSwitchDriveEn[0] && !switchEn)
		else $error("single input not opened on line overvoltage");
	a_cell_sink: assert property (@(posedge clk_sys) disable iff (rst)
		cellSinkEn |-> $past(ctrl_q[csf_pkg::CTL_CELL_DIS]) && $past(cellOvervoltage))
		else $error("cell sink on without enable");
endmodule
`default_nettype wire

// *** csf_pkg.sv ***
// Shared constants for the charger status, fault and interrupt block
package csf_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_FLAG = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;
	localparam logic [7:0] OFS_FLD = 8'h10;
	// Control register fields
	localparam int CTL_IND_DIS = 0;
	localparam int CTL_RETRY_OFF = 1;
	localparam int CTL_CELL_DIS = 2;
	localparam int CTL_SUSPEND = 3;
	localparam logic [3:0] CTL_RESET = 4'h0;
	// Event bit positions in status, flag and mask
	localparam int NEV = 17;
	localparam int EV_SRC = 0;
	localparam int EV_BUSOV = 1;
	localparam int EV_LINE0 = 2;
	localparam int EV_LINE1 = 3;
	localparam int EV_RAILOV = 4;
	localparam int EV_SHORT = 5;
	localparam int EV_CELLOV = 6;
	localparam int EV_EXT = 7;
	localparam int NEXT = 8;
	localparam int EV_PORT = 15;
	localparam int EV_FLD = 16;
	localparam logic [16:0] MASK_RESET = 17'h00000;
	// Timing figures and clock rate
	localparam longint CLK_HZ = 125000000;
	localparam longint LOAD_MS = 30;
	localparam longint IRQ_US = 256;
	localparam longint BLINK_HZ = 1;
	localparam longint RETRY_MS = 2;
	localparam longint LOAD_CYC = CLK_HZ * LOAD_MS / 1000;
	localparam longint IRQ_CYC = CLK_HZ * IRQ_US / 1000000;
	localparam longint BLINK_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam longint RETRY_CYC = CLK_HZ * RETRY_MS / 1000;
	localparam logic [2:0] SHORT_TRIES = 3'h7;
	// AXI responses
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// Source qualification and short retry states
	typedef enum logic [1:0] {Q_IDLE = 2'b00, Q_TEST = 2'b01, Q_GOOD = 2'b10} csf_qual_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_HOLD = 2'b01, S_WATCH = 2'b10} csf_short_t;
endpackage

// *** csf_host_model.sv ***
// Host side model that counts and times interrupt pulses
`timescale 1ns/1ns
`default_nettype none
module csf_host_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Interrupt line from the charger
	input wire logic irq_pulse_n,
	// What the host has seen
	output var int pulseCount,
	output var int lastWidth
);
	int lowRun;
	// A pulse counts only once it is released, so its width is known
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lowRun <= 0;
			pulseCount <= 0;
			lastWidth <= 0;
		end else if (irq_pulse_n === 1'b0) begin
			lowRun <= lowRun + 1;
		end else if (lowRun != 0) begin
			pulseCount <= pulseCount + 1;
			lastWidth <= lowRun;
			lowRun <= 0;
		end
	end
endmodule
`default_nettype wire

// *** charger_status_fault_irq_tb.sv ***
// Self-checking bench for the charger status, fault and interrupt block
`timescale 1ns/1ns
`default_nettype none
module charger_status_fault_irq_tb;
	localparam int IRQ = 16;
	localparam int BLINK = 8;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic [3:0] wStrb = 4'h0;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp, rsp;
	logic [31:0] rData, rd;
	logic busPres = 0, busOv = 0, busHys = 0, weakSrc = 0, dual = 0, railOv = 0;
	logic railSh = 0, iLim = 0, cellOv = 0, portDone = 0, chg = 0, topOff = 0;
	logic [1:0] lineOv = 2'h0;
	logic [7:0] ext = 8'h00;
	logic [2:0] phase = 3'h0;
	logic pgN, indOe, irqN, swEn, chgEn, regEn, ltSink, railSink, cellSink, cycLim;
	logic detReq, indOut;
	logic [1:0] drvEn;
	int pulseCount, lastWidth, failCount = 0, checksDone = 0;

	// Free-running system clock
	always #4 clk_sys = ~clk_sys;

	csf_charger_irq #(.LOAD_CYC(20), .IRQ_CYC(IRQ), .BLINK_CYC(BLINK), .RETRY_CYC(10)) i_dut (
		.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.busPresent(busPres), .busOvervoltage(busOv), .busAboveWeakHys(busHys),
		.weakSource(weakSrc), .lineOvervoltage(lineOv), .dualInput(dual),
		.railOvervoltage(railOv), .railShort(railSh), .inputCurrentLimitLoop(iLim),
		.cellOvervoltage(cellOv), .portDetectDone(portDone), .extEvents(ext),
		.sourceTypeField(4'h0), .thermistorZoneStatus(3'h0), .chargePhaseField(phase),
		.charging(chg), .topOff(topOff), .power_good_n(pgN), .chgIndOut(indOut),
		.chgIndOe(indOe), .irq_pulse_n(irqN), .switchEn(swEn), .chargeEn(chgEn),
		.internalRegulatorEn(regEn), .inputSwitchDriveEn(drvEn), .loadTestSinkEn(ltSink),
		.detectReq(detReq), .railSinkEn(railSink), .cellSinkEn(cellSink), .cycleLimitEn(cycLim)
	);

	csf_host_model i_host (
		.clk_sys(clk_sys), .rst(rst), .irq_pulse_n(irqN),
		.pulseCount(pulseCount), .lastWidth(lastWidth)
	);

	// Verdict and end of run, also reached when a wait runs out
	task tally_and_finish;
		if (failCount == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			failCount++;
		end
	endtask

	// A wait that used up its bound ends the run as a failure
	task automatic limit(input int i, input int n);
		if (i >= n) begin
			$display("MISMATCH wait expected done seen timeout");
			failCount++;
			tally_and_finish;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Bus write; the trailing edge keeps bready from being driven twice at one edge
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		int i;
		awAddr <= a;
		wData <= d;
		wStrb <= 4'hF;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk_sys);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
			if (bValid) break;
		end
		rsp = bResp;
		bReady <= 1'b0;
		limit(i, 40);
		@(posedge clk_sys);
	endtask

	task automatic axiRd(input logic [7:0] a);
		int i;
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk_sys);
			if (arReady) arValid <= 1'b0;
			if (rValid) break;
		end
		rd = rData;
		rsp = rResp;
		rReady <= 1'b0;
		limit(i, 40);
		@(posedge clk_sys);
	endtask

	task automatic waitIrq(input int n);
		int i;
		for (i = 0; i < 300 && pulseCount < n; i++) @(posedge clk_sys);
		limit(i, 300);
	endtask

	task automatic scnReset;
		chk("pg pin", pgN, 1);
		chk("irq pin", irqN, 1);
		axiRd(csf_pkg::OFS_MASK);
		chk("mask reset", rd, 0);
		axiRd(8'h2C);
		chk("unmapped read", rsp, csf_pkg::RESP_ERR);
		axiWr(csf_pkg::OFS_STAT, 32'h1);
		chk("read-only write", rsp, csf_pkg::RESP_ERR);
	endtask

	// Qualification, then the flag is read twice to see it clear
	task automatic scnSource;
		int n;
		n = pulseCount;
		busPres <= 1'b1;
		busHys <= 1'b1;
		tick(3);
		chk("load sink", ltSink, 1);
		chk("pg early", pgN, 1);
		waitIrq(n + 1);
		chk("pg pin", pgN, 0);
		chk("pulse width", lastWidth, IRQ);
		chk("detect request", detReq, 1);
		// Port detection completing raises its own status edge and pulse
		portDone <= 1'b1;
		waitIrq(n + 2);
		chk("detect done", detReq, 0);
		axiRd(csf_pkg::OFS_STAT);
		chk("src status", rd[0], 1);
		axiRd(csf_pkg::OFS_FLAG);
		chk("src flag", rd[0], 1);
		axiRd(csf_pkg::OFS_FLAG);
		chk("flag cleared", rd[0], 0);
	endtask

	task automatic scnBusOv;
		int n, tog;
		logic last;
		axiWr(csf_pkg::OFS_MASK, 32'h2);
		n = pulseCount;
		tog = 0;
		busOv <= 1'b1;
		tick(4);
		chk("busov switch", swEn, 0);
		chk("busov pg", pgN, 1);
		chk("busov regulator", regEn, 1);
		last = indOe;
		// The indicator must change at least twice over three half periods
		repeat (3 * BLINK + 2) begin
			@(posedge clk_sys);
			if (indOe !== last) tog++;
			last = indOe;
		end
		chk("blink", tog >= 2, 1);
		chk("masked pulse", pulseCount, n);
		axiRd(csf_pkg::OFS_FLAG);
		chk("busov flag", rd[1], 1);
		busOv <= 1'b0;
		axiWr(csf_pkg::OFS_MASK, 32'h0);
		tick(80);
		chk("busov resume", swEn, 1);
	endtask

	task automatic scnIndicator;
		chg <= 1'b1;
		tick(3);
		chk("ind charging", indOe, 1);
		chk("ind level", indOut, 0);
		topOff <= 1'b1;
		tick(3);
		chk("ind topoff", indOe, 0);
		topOff <= 1'b0;
		axiWr(csf_pkg::OFS_CTRL, 32'h1);
		tick(2);
		chk("ind disabled", indOe, 0);
		axiWr(csf_pkg::OFS_CTRL, 32'h0);
		tick(2);
		chk("ind enabled", indOe, 1);
		axiWr(csf_pkg::OFS_CTRL, 32'h8);
		tick(2);
		chk("ind suspend", indOe, 0);
		axiWr(csf_pkg::OFS_CTRL, 32'h0);
		chg <= 1'b0;
		tick(3);
		chk("ind idle", indOe, 0);
	endtask

	// Each of the eight external event inputs in turn, then a field change
	task automatic scnEvents;
		int n;
		n = pulseCount;
		for (int k = 0; k < 8; k++) begin
			ext <= 8'h01 << k;
			tick(IRQ + 4);
		end
		ext <= 8'h00;
		phase <= 3'h3;
		tick(IRQ + 4);
		chk("event pulses", pulseCount, n + 9);
		axiRd(csf_pkg::OFS_FLAG);
		chk("event flags", rd[16:7], 10'h2FF);
	endtask

	task automatic scnRail;
		int j;
		railOv <= 1'b1;
		tick(3);
		chk("rail sink", railSink, 1);
		chk("rail switch", swEn, 0);
		railOv <= 1'b0;
		axiWr(csf_pkg::OFS_CTRL, 32'h2);
		iLim <= 1'b1;
		railSh <= 1'b1;
		tick(4);
		chk("cycle limit", cycLim, 1);
		axiRd(csf_pkg::OFS_STAT);
		chk("short status", rd[5], 1);
		railSh <= 1'b0;
		axiWr(csf_pkg::OFS_CTRL, 32'h0);
		railSh <= 1'b1;
		tick(3);
		chk("short stop", swEn, 0);
		for (j = 0; j < 200; j++) begin
			axiRd(csf_pkg::OFS_CTRL);
			if (rd[3] === 1'b1) break;
		end
		chk("suspend set", rd[3], 1);
		railSh <= 1'b0;
		iLim <= 1'b0;
		axiWr(csf_pkg::OFS_CTRL, 32'h0);
	endtask

	task automatic scnCell;
		chg <= 1'b1;
		cellOv <= 1'b1;
		tick(3);
		chk("cell charge", chgEn, 0);
		chk("cell sink off", cellSink, 0);
		axiWr(csf_pkg::OFS_CTRL, 32'h4);
		tick(2);
		chk("cell sink on", cellSink, 1);
		cellOv <= 1'b0;
		chg <= 1'b0;
		axiWr(csf_pkg::OFS_CTRL, 32'h0);
	endtask

	task automatic scnLine;
		lineOv <= 2'b01;
		tick(3);
		chk("line drive", drvEn[0], 0);
		chk("line switch", swEn, 0);
		lineOv <= 2'b00;
		tick(3);
		chk("line back", drvEn[0], 1);
		dual <= 1'b1;
		tick(3);
		lineOv <= 2'b01;
		tick(3);
		chk("dual swap", drvEn, 2'b10);
		axiRd(csf_pkg::OFS_STAT);
		chk("dual status", rd[2], 1);
		lineOv <= 2'b00;
		dual <= 1'b0;
		tick(4);
	endtask

	task automatic scnWeak;
		portDone <= 1'b1;
		tick(40);
		weakSrc <= 1'b1;
		busHys <= 1'b0;
		tick(3);
		chk("weak switch", swEn, 0);
		axiRd(csf_pkg::OFS_STAT);
		chk("weak status", {rd[15], rd[0]}, 2'b00);
		weakSrc <= 1'b0;
		busHys <= 1'b1;
		tick(3);
		chk("requalify", ltSink, 1);
	endtask

	// Main sequence after a two-cycle reset
	initial begin
		tick(2);
		rst <= 1'b0;
		tick(1);
		scnReset;
		scnSource;
		scnBusOv;
		scnIndicator;
		scnEvents;
		scnRail;
		scnCell;
		scnLine;
		scnWeak;
		tally_and_finish;
	end

	// Overall limit on the run
	initial begin
		#400000;
		failCount++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
